// File: core/dcff_pkg.sv
// constants for the fifo status-flag and bus-matching core
// assumes one clock for both ports and a classic wishbone slave
`default_nettype none

package dcff_pkg;

   // geometry: storage is kept in 9-bit bytes
   localparam int BYTE_W    = 9;
   localparam int WORD_W    = 18;
   localparam int PTR_W     = 11;
   localparam int ADDR_W    = 10;
   localparam int MEM_BYTES = 1024;

   localparam logic [10:0] CAP_BYTES    = 11'h400;
   localparam logic [10:0] DEPTH_WIDE   = 11'h200;
   localparam logic [10:0] DEPTH_NARROW = 11'h400;
   localparam logic [10:0] HALF_WIDE    = 11'h100;
   localparam logic [10:0] HALF_NARROW  = 11'h200;
   localparam logic [10:0] STEP_NARROW  = 11'h001;
   localparam logic [10:0] STEP_WIDE    = 11'h002;

   // register byte offsets
   localparam logic [7:0] REG_CFG       = 8'h00;
   localparam logic [7:0] REG_EMPTY_OFS = 8'h04;
   localparam logic [7:0] REG_FULL_OFS  = 8'h08;
   localparam logic [7:0] REG_STATUS    = 8'h0C;
   localparam logic [7:0] REG_LEVEL     = 8'h10;

   // configuration fields
   localparam int CFG_FIRST_WORD_FALLTHROUGH_MODE   = 0;
   localparam int CFG_TIMING = 1;
   localparam int CFG_ORDER  = 2;
   localparam int CFG_IN9    = 3;
   localparam int CFG_OUT9   = 4;
   localparam int CFG_W      = 5;

   // status fields
   localparam int ST_EF      = 0;
   localparam int ST_FF      = 1;
   localparam int ST_PAE     = 2;
   localparam int ST_PAF     = 3;
   localparam int ST_HF      = 4;
   localparam int ST_OUTV    = 5;
   localparam int ST_ACT_LSB = 8;

   // reset values
   localparam logic [4:0]  CFG_RST       = 5'h02;
   localparam logic [10:0] EMPTY_OFS_RST = 11'h07F;
   localparam logic [10:0] FULL_OFS_RST  = 11'h07F;

endpackage

`default_nettype wire

// File: core/dcff_core.sv
// fifo status flags, bus matching and wishbone register slave
// assumes writer and reader share clk_i; inputs synchronous to it
//
// Function
// - standard mode almost-empty low at count <= n
// - fall-through almost-empty low at count <= n+1
// - asynchronous almost-empty asserts on read side
// - asynchronous almost-empty clears on write side
// - synchronous almost-empty changes on read side only
// - half-full low when write passes half depth
// - half-full high when read reaches half depth
// - standard half-full after D/2+1 writes
// - fall-through half-full after (D-1)/2+2 writes
// - depth 512 words wide, doubled both narrow
// - fall-through depth one more via output register
// - 18-bit output or lower nine bits
// - big-endian upper byte first, little swaps
// - two narrow writes form one wide word
// - output-ready low two cycles after write
// - empty deasserts shortly after write into empty
// - full deasserts shortly after read from full
// - input-ready low shortly after read frees space
// - synchronous almost-empty clears shortly after write
// - synchronous almost-full clears shortly after read
// - output-ready high only on a true read
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module dcff_core (
   // system
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // fifo resets
   input  wire logic        master_reset_n_i,
   input  wire logic        partial_reset_n_i,
   // write port
   input  wire logic        write_en_n_i,
   input  wire logic [17:0] write_data_in_i,
   // read port
   input  wire logic        read_en_n_i,
   output logic      [17:0] read_data_out_o,
   // flags
   output logic             empty_flag_n_o,
   output logic             full_flag_n_o,
   output logic             prog_almost_empty_n_o,
   output logic             prog_almost_full_n_o,
   output logic             half_full_n_o
);

   localparam int PW = dcff_pkg::PTR_W;
   localparam int AW = dcff_pkg::ADDR_W;

   ////////////////////////////////////////////////////////////////////
   // functions

   function automatic logic [PW-1:0] to_words(input logic [PW-1:0] b,
                                              input logic w);
      return w ? {1'b0, b[PW-1:1]} : b;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // state

   logic [8:0]    mem [0:dcff_pkg::MEM_BYTES-1];
   logic [4:0]    cfg;
   logic [4:0]    act;
   logic [PW-1:0] empty_ofs;
   logic [PW-1:0] full_ofs;
   logic [PW-1:0] wptr;
   logic [PW-1:0] rptr;
   logic [PW-1:0] wptr_sync;
   logic [PW-1:0] rptr_sync;
   logic          out_valid;

   ////////////////////////////////////////////////////////////////////
   // mode decode

   wire logic       clr = rst_i | ~master_reset_n_i | ~partial_reset_n_i;
   wire logic [4:0] next_act = rst_i ? dcff_pkg::CFG_RST :
                     (~master_reset_n_i ? cfg : act);
   wire logic first_word_fallthrough_mode   = act[dcff_pkg::CFG_FIRST_WORD_FALLTHROUGH_MODE];
   wire logic sync_t = act[dcff_pkg::CFG_TIMING];
   wire logic le     = act[dcff_pkg::CFG_ORDER];
   wire logic in9    = act[dcff_pkg::CFG_IN9];
   wire logic out9   = act[dcff_pkg::CFG_OUT9];
   wire logic wide   = ~(in9 & out9);
   wire logic swap   = le & ~in9 & out9;

   wire logic [PW-1:0] step_in  = in9 ? dcff_pkg::STEP_NARROW :
                                        dcff_pkg::STEP_WIDE;
   wire logic [PW-1:0] step_out = out9 ? dcff_pkg::STEP_NARROW :
                                         dcff_pkg::STEP_WIDE;
   wire logic [PW-1:0] dcap = wide ? dcff_pkg::DEPTH_WIDE :
                                     dcff_pkg::DEPTH_NARROW;
   wire logic [PW-1:0] half = wide ? dcff_pkg::HALF_WIDE :
                                     dcff_pkg::HALF_NARROW;

   ////////////////////////////////////////////////////////////////////
   // write side

   wire logic [PW-1:0] wr_free = dcff_pkg::CAP_BYTES - (wptr - rptr_sync);
   wire logic wr_ok = ~clr & ~write_en_n_i & (wr_free >= step_in);
   wire logic [PW-1:0] wptr_next = wr_ok ? wptr + step_in : wptr;
   wire logic [PW-1:0] wused_n = wptr_next - rptr_sync;
   wire logic [8:0] byte_first  = (in9 | swap) ? write_data_in_i[8:0] :
                                  write_data_in_i[17:9];
   wire logic [8:0] byte_second = swap ? write_data_in_i[17:9] :
                                  write_data_in_i[8:0];
   wire logic [AW-1:0] wadr_2nd = wptr[AW-1:0] + 10'h001;

   ////////////////////////////////////////////////////////////////////
   // read side

   wire logic have = (wptr_sync - rptr) >= step_out;
   wire logic consume = ~clr & ~read_en_n_i &
                        (first_word_fallthrough_mode ? out_valid : (empty_flag_n_o & have));
   wire logic take = first_word_fallthrough_mode ? (~clr & (~out_valid | consume) & have) :
                            consume;
   wire logic next_out_valid = take | (out_valid & ~consume);
   wire logic [PW-1:0] rptr_next = take ? rptr + step_out : rptr;
   wire logic [PW-1:0] ravail_n = wptr_sync - rptr_next;
   wire logic [AW-1:0] radr_2nd = rptr[AW-1:0] + 10'h001;
   wire logic [8:0] rb0 = mem[rptr[AW-1:0]];
   wire logic [8:0] rb1 = mem[radr_2nd];
   wire logic [17:0] formed = out9 ? {9'h000, rb0} :
                              (le ? {rb1, rb0} : {rb0, rb1});

   ////////////////////////////////////////////////////////////////////
   // flag terms

   wire logic [PW-1:0] pae_thr = empty_ofs + PW'(first_word_fallthrough_mode);
   wire logic [PW-1:0] rd_words = to_words(ravail_n, wide) +
                                  PW'(first_word_fallthrough_mode & next_out_valid);
   wire logic [PW-1:0] wr_words = to_words(wused_n, wide) +
                                  PW'(first_word_fallthrough_mode & out_valid);
   wire logic pae_cond  = rd_words <= pae_thr;
   wire logic pae_clear = wr_words > pae_thr;
   wire logic next_pae = sync_t ? ~pae_cond :
                         (pae_cond ? 1'b0 :
                         (pae_clear ? 1'b1 : prog_almost_empty_n_o));
   wire logic next_ef = first_word_fallthrough_mode ? ~next_out_valid :
                        (ravail_n >= step_out);
   wire logic next_ff = (dcff_pkg::CAP_BYTES - wused_n) >= step_in;
   wire logic next_paf = to_words(wused_n, wide) < (dcap - full_ofs);
   wire logic [PW-1:0] diff_n = wptr_next - rptr_next;
   wire logic hf_over = to_words(diff_n, wide) > half;
   wire logic next_hf = (wr_ok & hf_over) ? 1'b0 :
                        ((take & ~hf_over) ? 1'b1 :
                        half_full_n_o);

   ////////////////////////////////////////////////////////////////////
   // storage and pointers

   always_ff @(posedge clk_i) begin
      if (wr_ok) begin
         mem[wptr[AW-1:0]] <= byte_first;
         if (!in9) begin
            mem[wadr_2nd] <= byte_second;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr) begin
         wptr      <= '0;
         rptr      <= '0;
         wptr_sync <= '0;
         rptr_sync <= '0;
      end else begin
         wptr      <= wptr_next;
         rptr      <= rptr_next;
         wptr_sync <= wptr;
         rptr_sync <= rptr;
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr) begin
         out_valid       <= 1'b0;
         read_data_out_o <= 18'h00000;
      end else begin
         out_valid <= next_out_valid;
         if (take) begin
            read_data_out_o <= formed;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flags

   always_ff @(posedge clk_i) begin
      act <= next_act;
      if (clr) begin
         empty_flag_n_o        <= next_act[dcff_pkg::CFG_FIRST_WORD_FALLTHROUGH_MODE];
         full_flag_n_o         <= ~next_act[dcff_pkg::CFG_FIRST_WORD_FALLTHROUGH_MODE];
         prog_almost_empty_n_o <= 1'b0;
         prog_almost_full_n_o  <= 1'b1;
         half_full_n_o         <= 1'b1;
      end else begin
         empty_flag_n_o        <= next_ef;
         full_flag_n_o         <= first_word_fallthrough_mode ? ~next_ff : next_ff;
         prog_almost_empty_n_o <= next_pae;
         prog_almost_full_n_o  <= next_paf;
         half_full_n_o         <= next_hf;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // wishbone slave

   wire logic bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire logic bus_wr  = bus_req & wb_we_i;
   wire logic [31:0] m_cfg = merge({27'h0000000, cfg}, wb_dat_i, wb_sel_i);
   wire logic [31:0] m_eo  = merge({21'h000000, empty_ofs}, wb_dat_i,
                                   wb_sel_i);
   wire logic [31:0] m_fo  = merge({21'h000000, full_ofs}, wb_dat_i,
                                   wb_sel_i);
   logic [31:0] status;

   always_comb begin
      status = 32'h00000000;
      status[dcff_pkg::ST_EF]   = empty_flag_n_o;
      status[dcff_pkg::ST_FF]   = full_flag_n_o;
      status[dcff_pkg::ST_PAE]  = prog_almost_empty_n_o;
      status[dcff_pkg::ST_PAF]  = prog_almost_full_n_o;
      status[dcff_pkg::ST_HF]   = half_full_n_o;
      status[dcff_pkg::ST_OUTV] = out_valid;
      status[dcff_pkg::ST_ACT_LSB +: dcff_pkg::CFG_W] = act;
   end

   wire logic [31:0] rd_mux =
      (wb_adr_i == dcff_pkg::REG_CFG)       ? {27'h0000000, cfg} :
      (wb_adr_i == dcff_pkg::REG_EMPTY_OFS) ? {21'h000000, empty_ofs} :
      (wb_adr_i == dcff_pkg::REG_FULL_OFS)  ? {21'h000000, full_ofs} :
      (wb_adr_i == dcff_pkg::REG_STATUS)    ? status :
      (wb_adr_i == dcff_pkg::REG_LEVEL)     ?
         {21'h000000, to_words(wptr_sync - rptr, wide)} : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg       <= dcff_pkg::CFG_RST;
         empty_ofs <= dcff_pkg::EMPTY_OFS_RST;
         full_ofs  <= dcff_pkg::FULL_OFS_RST;
         wb_ack_o  <= 1'b0;
         wb_dat_o  <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_mux : wb_dat_o;
         if (bus_wr && wb_adr_i == dcff_pkg::REG_CFG) begin
            cfg <= m_cfg[4:0];
         end
         if (bus_wr && wb_adr_i == dcff_pkg::REG_EMPTY_OFS) begin
            empty_ofs <= m_eo[PW-1:0];
         end
         if (bus_wr && wb_adr_i == dcff_pkg::REG_FULL_OFS) begin
            full_ofs <= m_fo[PW-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (clr);

   wire logic [PW-1:0] lvl = to_words(wptr_sync - rptr, wide);
   wire logic [PW-1:0] lvl_all = lvl + PW'(first_word_fallthrough_mode & out_valid);
   wire logic empty_now = (wptr == rptr) & ~out_valid & (~in9 | out9);

   sequence s_write_empty;
      wr_ok && empty_now && read_en_n_i;
   endsequence

   chk_pae_std_level: assert property (
      sync_t && !first_word_fallthrough_mode && $stable(wptr_sync) && $stable(act) |->
         (!prog_almost_empty_n_o == (lvl <= empty_ofs)))
      else $error("almost-empty wrong in standard mode");

   chk_pae_first_word_fallthrough_mode_level: assert property (
      sync_t && first_word_fallthrough_mode && $stable(wptr_sync) && $stable(act) |->
         (!prog_almost_empty_n_o == (lvl_all <= empty_ofs + 11'h001)))
      else $error("almost-empty wrong in fall-through mode");

   chk_pae_async_set: assert property (
      !sync_t && $stable(wptr_sync) && $stable(act) &&
         lvl_all <= pae_thr |-> !prog_almost_empty_n_o)
      else $error("asynchronous almost-empty not asserted");

   chk_pae_async_clr: assert property (
      !sync_t && $rose(prog_almost_empty_n_o) |-> $past(pae_clear))
      else $error("asynchronous almost-empty cleared without cause");

   chk_hf_set_write: assert property (
      wr_ok && hf_over |=> !half_full_n_o)
      else $error("half-full not set by write");

   chk_hf_clr_read: assert property (
      take && !hf_over && !(wr_ok && hf_over) |=> half_full_n_o)
      else $error("half-full not cleared by read");

   chk_ef_write_lat: assert property (
      s_write_empty and !first_word_fallthrough_mode |->
         ##1 !empty_flag_n_o [*2] ##1 empty_flag_n_o)
      else $error("empty flag latency wrong");

   chk_or_write_lat: assert property (
      s_write_empty and first_word_fallthrough_mode |->
         ##1 empty_flag_n_o [*2] ##1 !empty_flag_n_o)
      else $error("output-ready latency wrong");

   chk_or_true_read: assert property (
      first_word_fallthrough_mode && $rose(empty_flag_n_o) && !$past(clr) |->
         $past(!read_en_n_i) && $stable(read_data_out_o))
      else $error("output-ready rose without a read");

endmodule

`default_nettype wire

// File: verif/dcff_party.sv
// writer and reader model driving the fifo core ports
// assumes clk_i is shared with the core and flags are active low
`timescale 1ns/100ps
`default_nettype none

module dcff_party (
   // system
   input  wire logic        clk_i,
   // flag watched by the reader
   input  wire logic        empty_flag_n_i,
   // write and read ports
   output logic             write_en_n_o,
   output logic      [17:0] write_data_in_o,
   output logic             read_en_n_o
);
   initial begin
      write_en_n_o    = 1'b1;
      write_data_in_o = 18'h15555;
      read_en_n_o     = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   // one write per call, calls chain back to back
   task automatic push(input logic [17:0] d);
      @(posedge clk_i);
      write_en_n_o    <= 1'b0;
      write_data_in_o <= d;
   endtask

   // end a burst, released data lines carry no stale word
   task automatic stop();
      @(posedge clk_i);
      write_en_n_o    <= 1'b1;
      write_data_in_o <= ~write_data_in_o;
   endtask

   // one read once the flag shows data in its own clock domain
   task automatic pull(input logic first_word_fallthrough_mode, output logic ok);
      repeat (20) if (empty_flag_n_i !== ~first_word_fallthrough_mode) @(posedge clk_i);
      ok = (empty_flag_n_i === ~first_word_fallthrough_mode);
      if (ok) begin
         @(posedge clk_i);
         read_en_n_o <= 1'b0;
         @(posedge clk_i);
         read_en_n_o <= 1'b1;
      end
   endtask
endmodule

`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the fifo flag and bus-matching core
// assumes dcff_pkg, dcff_core and the port model dcff_party
`timescale 1ns/100ps
`default_nettype none

module tb;
   logic        clk_i;
   logic        rst_i    = 1'b1;
   logic        wb_cyc   = 1'b0;
   logic        wb_we    = 1'b0;
   logic [7:0]  wb_adr   = 8'h00;
   logic [31:0] wb_dat   = 32'h0;
   logic        mrs_n    = 1'b1;
   logic        prs_n    = 1'b1;
   logic [31:0] wb_q;
   logic        wb_ack, wen_n, ren_n, ef, prog_almost_empty_n, hf, ff, prog_almost_full_n;
   logic [17:0] wdat, q;
   int          n_errors = 0;
   int          n_tests  = 0;

   dcff_core u_dut (
      .clk_i                 (clk_i),
      .rst_i                 (rst_i),
      .wb_cyc_i              (wb_cyc),
      .wb_stb_i              (wb_cyc),
      .wb_we_i               (wb_we),
      .wb_adr_i              (wb_adr),
      .wb_sel_i              (4'hF),
      .wb_dat_i              (wb_dat),
      .wb_dat_o              (wb_q),
      .wb_ack_o              (wb_ack),
      .master_reset_n_i      (mrs_n),
      .partial_reset_n_i     (prs_n),
      .write_en_n_i          (wen_n),
      .write_data_in_i       (wdat),
      .read_en_n_i           (ren_n),
      .read_data_out_o       (q),
      .empty_flag_n_o        (ef),
      .full_flag_n_o         (ff),
      .prog_almost_empty_n_o (prog_almost_empty_n),
      .prog_almost_full_n_o  (prog_almost_full_n),
      .half_full_n_o         (hf)
   );

   dcff_party u_party (
      .clk_i           (clk_i),
      .empty_flag_n_i  (ef),
      .write_en_n_o    (wen_n),
      .write_data_in_o (wdat),
      .read_en_n_o     (ren_n)
   );

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask

   // classic single cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_we  <= w;
      wb_adr <= a;
      wb_dat <= d;
      @(posedge clk_i);
      while (wb_ack !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 50)
         n_errors++;
      r = wb_q;
      wb_cyc <= 1'b0;
   endtask

   task automatic pulse_prs();
      @(posedge clk_i);
      prs_n <= 1'b0;
      @(posedge clk_i);
      prs_n <= 1'b1;
   endtask

   task automatic set_mode(input logic [4:0] c);
      logic [31:0] r;
      wb(1'b1, dcff_pkg::REG_CFG, {27'h0, c}, r);
      @(posedge clk_i);
      mrs_n <= 1'b0;
      @(posedge clk_i);
      mrs_n <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [31:0] r;
      wb(1'b0, dcff_pkg::REG_CFG, 32'h0, r);
      chk("cfg", 32'h02, r);
      wb(1'b0, dcff_pkg::REG_EMPTY_OFS, 32'h0, r);
      chk("empty_ofs", 32'h7F, r);
      wb(1'b0, 8'h40, 32'h0, r);
      chk("unmapped", 32'h0, r);
   endtask

   task automatic t_pae(input logic f, input logic t);
      logic [31:0] r;
      logic        ok;
      wb(1'b1, dcff_pkg::REG_EMPTY_OFS, 32'h2, r);
      set_mode({3'h0, t, f});
      repeat (2 + f) u_party.push(18'h00011);
      u_party.stop();
      repeat (4) @(posedge clk_i);
      #1;
      chk("pae at n", 32'h0, 32'(prog_almost_empty_n));
      u_party.push(18'h00022);
      u_party.stop();
      repeat (2) @(posedge clk_i);
      #1;
      chk("pae above n", 32'h1, 32'(prog_almost_empty_n));
      u_party.pull(f, ok);
      repeat (2) @(posedge clk_i);
      #1;
      chk("pae after read", 32'h0, 32'(prog_almost_empty_n));
      pulse_prs();
   endtask

   task automatic t_half(input logic f);
      logic ok;
      set_mode({4'h1, f});
      repeat (f ? 257 : 256) u_party.push(18'h00155);
      u_party.stop();
      repeat (3) @(posedge clk_i);
      #1;
      chk("hf below", 32'h1, 32'(hf));
      chk("ef", 32'(!f), 32'(ef));
      u_party.push(18'h002AA);
      u_party.stop();
      #1;
      chk("hf above", 32'h0, 32'(hf));
      u_party.pull(f, ok);
      #1;
      chk("hf after read", 32'h1, 32'(hf));
      pulse_prs();
   endtask

   task automatic t_full(input logic f);
      logic [31:0] r;
      logic        ok;
      wb(1'b1, dcff_pkg::REG_FULL_OFS, 32'h0, r);
      set_mode({4'h1, f});
      repeat (512 + f) u_party.push(18'h00133);
      u_party.stop();
      repeat (2) @(posedge clk_i);
      #1;
      chk("ff when full", 32'(f), 32'(ff));
      chk("paf when full", 32'h0, 32'(prog_almost_full_n));
      u_party.pull(f, ok);
      @(posedge clk_i);
      #1;
      chk("ff held", 32'(f), 32'(ff));
      @(posedge clk_i);
      #1;
      chk("ff released", 32'(!f), 32'(ff));
      chk("paf released", 32'h1, 32'(prog_almost_full_n));
      pulse_prs();
   endtask

   task automatic t_order();
      logic [4:0]  cfg [6] = '{5'h02, 5'h06, 5'h12, 5'h16, 5'h0A, 5'h0E};
      logic [8:0]  a = 9'h1A5;
      logic [8:0]  b = 9'h0C3;
      logic [17:0] e;
      logic        ok;
      for (int i = 0; i < 6; i++) begin
         set_mode(cfg[i]);
         if (cfg[i][3]) begin
            u_party.push({9'h000, a});
            u_party.push({9'h000, b});
         end else
            u_party.push({a, b});
         u_party.stop();
         repeat (2) @(posedge clk_i);
         #1;
         chk("ef after write", 32'h1, 32'(ef));
         for (int k = 0; k < (cfg[i][4] ? 2 : 1); k++) begin
            u_party.pull(1'b0, ok);
            #1;
            if (cfg[i][4])
               e = {9'h000, (cfg[i][2] ^ k[0]) ? b : a};
            else
               e = cfg[i][2] ? {b, a} : {a, b};
            chk("read data", 32'(e), 32'(q));
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      for (int i = 0; i < 4; i++) t_pae(i[0], i[1]);
      t_half(1'b0);
      t_half(1'b1);
      t_order();
      t_full(1'b0);
      t_full(1'b1);
      print_verdict();
   end

   initial begin
      #100000;
      n_errors++;
      print_verdict();
   end
endmodule

`default_nettype wire
